// file: src/rri_pkg.sv
// Purpose: shared constants and state types for the reset and initialization link
// Assumes: one 125 MHz clock (8 ns period) on both ends
// Notes: times keep their printed figure; cycle counts derive from them
package rri_pkg;

	// clock rate
	localparam int CLK_PERIOD_NS = 8;

	// power-up hold with reset asserted, a least time, rounded up
	localparam int POWERUP_HOLD_US = 200;
	localparam int POWERUP_HOLD_CYCLES = (POWERUP_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// reset pulse with stable power and clock, a least time, rounded up
	localparam int SOFT_RESET_NS = 100;
	localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// stabilization interval in the test band, a longest time, rounded down
	localparam int STAB_MAX_US = 15;
	localparam int STAB_CYCLES_RAW = (STAB_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int STAB_CYCLES = (STAB_CYCLES_RAW < 1) ? 1 : STAB_CYCLES_RAW;

	// extra wait on the controller side to cover the one-cycle pin registers
	localparam int STAB_MARGIN_CYCLES = 2;

	// activation interval before reset release; no figure given, plain default
	localparam int ACTIVATION_INTERVAL_CYCLES = 16;

	// widths and counts
	localparam int CMD_WIDTH = 24;
	localparam int CS_COUNT = 4;
	localparam int DUAL_CS_COUNT = 2;
	localparam int CNT_WIDTH = 24;

	// values after reset
	localparam logic [3:0] CS_IDLE = 4'hf;
	localparam logic [1:0] ODT_IDLE = 2'h0;

	// device end states
	typedef enum logic [1:0] {
		DEV_RESET = 2'b00,
		DEV_STAB = 2'b01,
		DEV_RUN = 2'b10
	} rri_dev_state_e;

	// controller end states
	typedef enum logic [2:0] {
		CTL_POWER = 3'b000,
		CTL_ACT = 3'b001,
		CTL_STAB = 3'b010,
		CTL_RUN = 3'b011,
		CTL_SOFT = 3'b100
	} rri_ctl_state_e;

endpackage : rri_pkg

// file: src/rri_link_if.sv
// Purpose: pins between the memory controller and the registering clock driver
// Assumes: both ends on clock_in; tri-state groups carry an active-low enable
// Notes: the open-drain error wire is resolved here with its pull-up
`timescale 1ns/1ns
interface rri_link_if #(
	parameter int CMD_WIDTH = rri_pkg::CMD_WIDTH
);
	// controller to device
	logic link_reset_n;
	logic clock_stable;
	logic quad_select_enable_n;
	logic [3:0] chip_select_in;
	logic clk_enable_in0;
	logic clk_enable_in1;
	logic termination_in0;
	logic termination_in1;
	logic [CMD_WIDTH-1:0] cmd_addr_in;
	// device to controller / memory devices
	logic [3:0] chip_select_out;
	logic chip_select_oe_n;
	logic clk_enable_out_a0;
	logic clk_enable_out_a1;
	logic clk_enable_out_b0;
	logic clk_enable_out_b1;
	logic [1:0] termination_out;
	logic termination_oe_n;
	logic [CMD_WIDTH-1:0] cmd_addr_out;
	logic cmd_addr_oe_n;
	logic parity_error_out;
	logic parity_error_oe_n;
	logic parity_error_level;

	// pull-up wins whenever the device releases the pin
	assign parity_error_level = parity_error_oe_n ? 1'b1 : parity_error_out;

	modport device (
		input link_reset_n, clock_stable, quad_select_enable_n, chip_select_in,
		input clk_enable_in0, clk_enable_in1, termination_in0, termination_in1, cmd_addr_in,
		output chip_select_out, chip_select_oe_n, clk_enable_out_a0, clk_enable_out_a1,
		output clk_enable_out_b0, clk_enable_out_b1, termination_out, termination_oe_n,
		output cmd_addr_out, cmd_addr_oe_n, parity_error_out, parity_error_oe_n
	);

	modport controller (
		output link_reset_n, clock_stable, quad_select_enable_n, chip_select_in,
		output clk_enable_in0, clk_enable_in1, termination_in0, termination_in1, cmd_addr_in,
		input parity_error_level
	);
endinterface : rri_link_if

// file: src/rri_device.sv
// Purpose: reset and initialization behaviour of the registering clock driver
// Assumes: link pins come from logic on clock_in, so no synchronisers are used
// Notes: link reset acts at the next clock edge; the stabilization count is internal
`timescale 1ns/1ns

// How it works
// - controller holds reset 200 us after power
// - receivers ignored while reset is low
// - control registers return to defaults in reset
// - clock-enable outputs low, all others floated
// - low-power state, termination off during reset
// - controller keeps selects high, clock stable
// - controller keeps clock-enables low during stabilization
// - no forwarding until stabilization interval ends
// - controller always drives reset to valid level
// - device starts in reset at power-up
// - leave reset only on rise with clock
// - reset asynchronous; clear, float, keep enables low (here reset is taken at the next clock edge)
// - two selects dual mode, four quad mode
// - error output released high during reset
// - termination outputs low until stabilization ends
// - controller soft reset lasts at least 100 ns
module rri_device
	import rri_pkg::*;
#(
	parameter int CMD_WIDTH = rri_pkg::CMD_WIDTH,
	parameter int STAB_CYCLES_P = rri_pkg::STAB_CYCLES
) (
	input wire logic clock_in,
	input wire logic reset_in,
	rri_link_if.device link,
	output logic low_power_out,
	output logic termination_on_out,
	output logic ready_out,
	output logic quad_mode_out
);
	import rri_pkg::*;

	rri_dev_state_e state;
	rri_dev_state_e next_state;
	logic link_reset_q;
	logic quad_mode;
	logic [CNT_WIDTH-1:0] stab_count;
	logic stab_done;
	logic in_reset;
	logic release_edge;
	logic [3:0] cs_active;
	logic [3:0] cs_enabled;
	logic [3:0] cs_low_bits;
	logic exactly_one;

	localparam logic [CNT_WIDTH-1:0] STAB_LAST = CNT_WIDTH'(STAB_CYCLES_P - 1);

	// reset seen from either the local reset or the link pin
	assign in_reset = reset_in | ~link.link_reset_n;
	// a release counts only with a stable clock present
	assign release_edge = link.link_reset_n & ~link_reset_q & link.clock_stable;
	assign stab_done = (stab_count == STAB_LAST);

	// previous link reset level; starts low so power-up looks like reset
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			link_reset_q <= 1'b0;
		end else begin
			link_reset_q <= link.link_reset_n;
		end
	end

	// state sequencing
	always_comb begin
		next_state = state;
		case (state)
			DEV_RESET: begin
				if (release_edge) begin
					next_state = DEV_STAB;
				end
			end
			DEV_STAB: begin
				if (stab_done) begin
					next_state = DEV_RUN;
				end
			end
			DEV_RUN: begin
				next_state = DEV_RUN;
			end
			default: begin
				next_state = DEV_RESET;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (in_reset) begin
			state <= DEV_RESET;
		end else begin
			state <= next_state;
		end
	end

	// stabilization count from the release of reset
	always_ff @(posedge clock_in) begin
		if (in_reset || state != DEV_STAB) begin
			stab_count <= '0;
		end else if (!stab_done) begin
			stab_count <= stab_count + CNT_WIDTH'(1);
		end
	end

	// mode strap is caught at the release edge, defaulted in reset
	always_ff @(posedge clock_in) begin
		if (in_reset) begin
			quad_mode <= 1'b0;
		end else if (state == DEV_RESET && release_edge) begin
			quad_mode <= ~link.quad_select_enable_n;
		end
	end

	// selects that count in the current mode; unused ones read as inactive
	genvar gi;
	generate
		for (gi = 0; gi < CS_COUNT; gi++) begin : g_cs
			assign cs_enabled[gi] = (gi < DUAL_CS_COUNT) ? 1'b1 : quad_mode;
			assign cs_active[gi] = cs_enabled[gi] & ~link.chip_select_in[gi];
			assign cs_low_bits[gi] = cs_enabled[gi] ? link.chip_select_in[gi] : 1'b1;
		end
	endgenerate

	// forward only when exactly one select is low
	assign exactly_one = (cs_active != 4'h0) && ((cs_active & (cs_active - 4'h1)) == 4'h0);

	// clock-enable outputs: low through reset and stabilization
	always_ff @(posedge clock_in) begin
		if (in_reset || state != DEV_RUN) begin
			link.clk_enable_out_a0 <= 1'b0;
			link.clk_enable_out_a1 <= 1'b0;
			link.clk_enable_out_b0 <= 1'b0;
			link.clk_enable_out_b1 <= 1'b0;
		end else begin
			link.clk_enable_out_a0 <= link.clk_enable_in0;
			link.clk_enable_out_a1 <= link.clk_enable_in1;
			link.clk_enable_out_b0 <= link.clk_enable_in0;
			link.clk_enable_out_b1 <= link.clk_enable_in1;
		end
	end

	// chip-select outputs: floated in reset, held high until running
	always_ff @(posedge clock_in) begin
		if (in_reset) begin
			link.chip_select_oe_n <= 1'b1;
			link.chip_select_out <= CS_IDLE;
		end else if (state != DEV_RUN) begin
			link.chip_select_oe_n <= 1'b0;
			link.chip_select_out <= CS_IDLE;
		end else begin
			link.chip_select_oe_n <= 1'b0;
			link.chip_select_out <= exactly_one ? cs_low_bits : CS_IDLE;
		end
	end

	// command/address outputs: float in reset, data passes only when running
	always_ff @(posedge clock_in) begin
		if (in_reset) begin
			link.cmd_addr_oe_n <= 1'b1;
			link.cmd_addr_out <= '0;
		end else if (state != DEV_RUN) begin
			link.cmd_addr_oe_n <= 1'b0;
			link.cmd_addr_out <= '0;
		end else begin
			link.cmd_addr_oe_n <= 1'b0;
			if (exactly_one) begin
				link.cmd_addr_out <= link.cmd_addr_in;
			end
		end
	end

	// termination outputs: float in reset, driven low while stabilizing
	always_ff @(posedge clock_in) begin
		if (in_reset) begin
			link.termination_oe_n <= 1'b1;
			link.termination_out <= ODT_IDLE;
		end else if (state != DEV_RUN) begin
			// driven low from the release edge itself; a refused release leaves the pins floated
			link.termination_oe_n <= (next_state == DEV_RESET);
			link.termination_out <= ODT_IDLE;
		end else begin
			link.termination_oe_n <= 1'b0;
			link.termination_out <= {link.termination_in1, link.termination_in0};
		end
	end

	// open-drain error: released, so the pull-up holds it high
	// parity checking itself is not part of this block
	always_ff @(posedge clock_in) begin
		if (in_reset) begin
			link.parity_error_oe_n <= 1'b1;
			link.parity_error_out <= 1'b0;
		end else begin
			link.parity_error_oe_n <= 1'b1;
			link.parity_error_out <= 1'b0;
		end
	end

	// power and termination state; receivers are off in the low-power state
	always_ff @(posedge clock_in) begin
		if (in_reset) begin
			low_power_out <= 1'b1;
			termination_on_out <= 1'b0;
		end else begin
			low_power_out <= (next_state == DEV_RESET);
			termination_on_out <= (next_state != DEV_RESET);
		end
	end

	// status towards local logic
	always_ff @(posedge clock_in) begin
		if (in_reset) begin
			ready_out <= 1'b0;
			quad_mode_out <= 1'b0;
		end else begin
			ready_out <= (next_state == DEV_RUN);
			quad_mode_out <= quad_mode;
		end
	end

endmodule : rri_device

// file: src/rri_controller.sv
// Purpose: controller end that sequences reset, selects and clock-enables
// Assumes: shares clock_in with the device end
// Notes: long hold counts are parameters so simulation can shorten them
`timescale 1ns/1ns
module rri_controller
	import rri_pkg::*;
#(
	parameter int CMD_WIDTH = rri_pkg::CMD_WIDTH,
	parameter int POWERUP_CYCLES_P = rri_pkg::POWERUP_HOLD_CYCLES,
	parameter int ACT_CYCLES_P = rri_pkg::ACTIVATION_INTERVAL_CYCLES,
	parameter int STAB_CYCLES_P = rri_pkg::STAB_CYCLES
) (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic soft_reset_in,
	input wire logic quad_mode_in,
	input wire logic [3:0] chip_select_in,
	input wire logic [1:0] clk_enable_in,
	input wire logic [1:0] termination_in,
	input wire logic [CMD_WIDTH-1:0] cmd_addr_in,
	rri_link_if.controller link,
	output logic ready_out,
	output logic parity_error_out
);
	import rri_pkg::*;

	rri_ctl_state_e state;
	logic [CNT_WIDTH-1:0] count;
	logic running;

	localparam logic [CNT_WIDTH-1:0] POWER_LAST = CNT_WIDTH'(POWERUP_CYCLES_P - 1);
	localparam logic [CNT_WIDTH-1:0] SOFT_LAST = CNT_WIDTH'(SOFT_RESET_CYCLES - 1);
	localparam logic [CNT_WIDTH-1:0] ACT_LAST = CNT_WIDTH'(ACT_CYCLES_P - 1);
	localparam logic [CNT_WIDTH-1:0] STAB_LAST = CNT_WIDTH'(STAB_CYCLES_P + STAB_MARGIN_CYCLES - 1);

	assign running = (state == CTL_RUN);

	// sequence: power hold or soft pulse, activation, stabilization, run
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state <= CTL_POWER;
			count <= '0;
		end else begin
			count <= count + CNT_WIDTH'(1);
			case (state)
				CTL_POWER: if (count == POWER_LAST) begin
					state <= CTL_ACT;
					count <= '0;
				end
				CTL_SOFT: if (count == SOFT_LAST) begin
					state <= CTL_ACT;
					count <= '0;
				end
				CTL_ACT: if (count == ACT_LAST) begin
					state <= CTL_STAB;
					count <= '0;
				end
				CTL_STAB: if (count == STAB_LAST) begin
					state <= CTL_RUN;
					count <= '0;
				end
				CTL_RUN: begin
					count <= '0;
					if (soft_reset_in) begin
						state <= CTL_SOFT;
					end
				end
				default: begin
					state <= CTL_POWER;
					count <= '0;
				end
			endcase
		end
	end

	// reset pin is always a driven level, low until stabilization starts
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			link.link_reset_n <= 1'b0;
			link.clock_stable <= 1'b0;
			link.quad_select_enable_n <= 1'b1;
		end else begin
			link.link_reset_n <= (state == CTL_STAB) || running;
			link.clock_stable <= (state != CTL_POWER);
			link.quad_select_enable_n <= ~quad_mode_in;
		end
	end

	// selects high and clock-enables low until running
	always_ff @(posedge clock_in) begin
		if (reset_in || !running) begin
			link.chip_select_in <= CS_IDLE;
			link.clk_enable_in0 <= 1'b0;
			link.clk_enable_in1 <= 1'b0;
			link.termination_in0 <= 1'b0;
			link.termination_in1 <= 1'b0;
			link.cmd_addr_in <= '0;
		end else begin
			link.chip_select_in <= chip_select_in;
			link.clk_enable_in0 <= clk_enable_in[0];
			link.clk_enable_in1 <= clk_enable_in[1];
			link.termination_in0 <= termination_in[0];
			link.termination_in1 <= termination_in[1];
			link.cmd_addr_in <= cmd_addr_in;
		end
	end

	// user status; error level is active low on the wire
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			ready_out <= 1'b0;
			parity_error_out <= 1'b0;
		end else begin
			ready_out <= running && !soft_reset_in;
			parity_error_out <= ~link.parity_error_level;
		end
	end

endmodule : rri_controller

// file: verif/rri_checker.sv
// Purpose: link checks for reset and init
// Assumes: one clock, reset_in high
// Notes: stab count of 8 in the bench
`timescale 1ns/1ns
module rri_checker (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic link_reset_n,
	input wire logic clock_stable,
	input wire logic [3:0] chip_select_in,
	input wire logic clk_enable_in0,
	input wire logic clk_enable_in1,
	input wire logic [3:0] chip_select_out,
	input wire logic chip_select_oe_n,
	input wire logic clk_enable_out_a0,
	input wire logic clk_enable_out_a1,
	input wire logic clk_enable_out_b0,
	input wire logic clk_enable_out_b1,
	input wire logic [1:0] termination_out,
	input wire logic termination_oe_n,
	input wire logic cmd_addr_oe_n,
	input wire logic parity_error_level
);
	logic [7:0] low_cnt;
	logic cke_any;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);
	// low edges on link reset, saturating so long holds never wrap
	always_ff @(posedge clock_in) begin
		if (reset_in || link_reset_n)
			low_cnt <= 8'h00;
		else if (low_cnt != 8'hff)
			low_cnt <= low_cnt + 8'h01;
	end
	// any copy of a clock enable high
	assign cke_any = clk_enable_out_a0 | clk_enable_out_a1 | clk_enable_out_b0 | clk_enable_out_b1;
	chk_cke_low_reset: assert property (!link_reset_n |=> !cke_any)
		else $error("clock enables not low in reset");
	chk_outs_float: assert property (!link_reset_n |=> chip_select_oe_n && cmd_addr_oe_n && termination_oe_n)
		else $error("outputs driven in reset");
	chk_error_released: assert property (parity_error_level)
		else $error("error pin pulled low");
	chk_cke_copies: assert property (clk_enable_out_a0 == clk_enable_out_b0 && clk_enable_out_a1 == clk_enable_out_b1)
		else $error("clock enable copies differ");
	chk_cke_hold_stab: assert property ($rose(link_reset_n) |=> (!cke_any)[*8])
		else $error("clock enable released early");
	chk_odt_low_stab: assert property ($rose(link_reset_n) |=> (termination_out == 2'h0 && !termination_oe_n)[*8])
		else $error("termination not held low");
	chk_ctl_cke_stab: assert property ($rose(link_reset_n) |-> (!clk_enable_in0 && !clk_enable_in1)[*8])
		else $error("controller clock enable high in stab");
	chk_sel_before_rel: assert property ($rose(link_reset_n) |-> chip_select_in == 4'hf && $past(chip_select_in) == 4'hf && clock_stable)
		else $error("selects or clock bad at release");
	chk_reset_length: assert property ($rose(link_reset_n) |-> low_cnt >= rri_pkg::SOFT_RESET_CYCLES)
		else $error("link reset too short");
	cov_release: cover property ($rose(link_reset_n));
	cov_soft: cover property ($fell(link_reset_n));
	cov_forward: cover property (!chip_select_oe_n && chip_select_out != 4'hf);
endmodule : rri_checker

// file: verif/rcd_reset_initialization_test.sv
// Purpose: both ends joined, reset and forwarding checks
// Assumes: stab count shortened to 8
// Notes: device compared after a 3-edge hold
`timescale 1ns/1ns
module rcd_reset_initialization_test;
	import rri_pkg::*;
	localparam int STAB = 8;
	localparam logic [3:0] CORNER [4] = '{4'he, 4'hf, 4'hc, 4'h7};
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic soft_reset = 1'b0;
	logic quad = 1'b0;
	logic [3:0] cs = 4'hf;
	logic [1:0] cke = 2'h0;
	logic [1:0] odt = 2'h0;
	logic [CMD_WIDTH-1:0] cmd = '0;
	logic dev_lp, dev_odt_on, dev_ready, dev_quad, ctl_ready, ctl_err;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	rri_link_if link ();
	rri_controller #(.POWERUP_CYCLES_P(20), .ACT_CYCLES_P(4), .STAB_CYCLES_P(STAB)) i_rri_controller (
		.clock_in(clock_in), .reset_in(reset_in), .soft_reset_in(soft_reset), .quad_mode_in(quad),
		.chip_select_in(cs), .clk_enable_in(cke), .termination_in(odt), .cmd_addr_in(cmd), .link(link),
		.ready_out(ctl_ready), .parity_error_out(ctl_err));
	rri_device #(.STAB_CYCLES_P(STAB)) i_rri_device (.clock_in(clock_in), .reset_in(reset_in), .link(link),
		.low_power_out(dev_lp), .termination_on_out(dev_odt_on), .ready_out(dev_ready), .quad_mode_out(dev_quad));
	rri_checker i_rri_checker (.clock_in(clock_in), .reset_in(reset_in), .link_reset_n(link.link_reset_n),
		.clock_stable(link.clock_stable), .chip_select_in(link.chip_select_in),
		.clk_enable_in0(link.clk_enable_in0), .clk_enable_in1(link.clk_enable_in1),
		.chip_select_out(link.chip_select_out), .chip_select_oe_n(link.chip_select_oe_n),
		.clk_enable_out_a0(link.clk_enable_out_a0), .clk_enable_out_a1(link.clk_enable_out_a1),
		.clk_enable_out_b0(link.clk_enable_out_b0), .clk_enable_out_b1(link.clk_enable_out_b1),
		.termination_out(link.termination_out), .termination_oe_n(link.termination_oe_n),
		.cmd_addr_oe_n(link.cmd_addr_oe_n), .parity_error_level(link.parity_error_level));
	// free-running clock
	initial begin
		forever #4 clock_in = ~clock_in;
	end
	// hang guard, well above the few hundred cycles needed
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			conclude();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	// selects pass only when exactly one enabled select is low
	function automatic logic [3:0] fwd_cs(input logic [3:0] c, input logic q);
		logic [3:0] m;
		m = q ? ~c : {2'h0, ~c[1:0]};
		return ($countones(m) == 1) ? c : 4'hf;
	endfunction : fwd_cs
	// wait for link release, then time the device until ready
	task automatic wait_ready();
		int n;
		n = 0;
		while (link.link_reset_n !== 1'b1 && n < 200) begin
			@(posedge clock_in);
			#1;
			n++;
		end
		n = 0;
		while (dev_ready !== 1'b1 && n < 50) begin
			check({link.clk_enable_out_a0, link.clk_enable_out_b1}, 2'h0, "cke in stab");
			@(posedge clock_in);
			#1;
			n++;
		end
		check(n, STAB + 1, "stab length");
	endtask : wait_ready
	// random traffic with corner selects first; mask hides unused selects in dual mode
	task automatic traffic(input int count);
		logic [3:0] c;
		logic [3:0] mask;
		mask = quad ? 4'h0 : 4'hc;
		for (int i = 0; i < count; i++) begin
			c = (i < 4) ? CORNER[i] : 4'($urandom);
			@(posedge clock_in);
			cs <= c;
			cke <= 2'($urandom);
			odt <= 2'($urandom);
			cmd <= CMD_WIDTH'($urandom);
			repeat (3) @(posedge clock_in);
			#1;
			check(link.chip_select_out | mask, fwd_cs(c, quad) | mask, "selects");
			if (fwd_cs(c, quad) != 4'hf)
				check(link.cmd_addr_out, cmd, "cmd");
			check({link.clk_enable_out_a1, link.clk_enable_out_a0, link.clk_enable_out_b1, link.clk_enable_out_b0},
				{cke, cke}, "cke");
			check(link.termination_out, odt, "termination");
			check({dev_lp, dev_odt_on, dev_ready, ctl_ready, ctl_err}, 5'h0e, "running status");
		end
		$display("test traffic quad=%0d done", quad);
	endtask : traffic
	// parked state while any reset is in force
	task automatic check_parked();
		check({dev_lp, dev_odt_on, dev_ready}, 3'h4, "low power");
		check({link.chip_select_oe_n, link.cmd_addr_oe_n, link.termination_oe_n}, 3'h7, "floated");
		check(link.parity_error_level, 1'b1, "error pin");
		check({ctl_ready, ctl_err}, 2'h0, "controller status");
	endtask : check_parked
	initial begin
		void'($urandom(32'h31a7834f));
		repeat (10) @(posedge clock_in);
		#1;
		check_parked();
		check(dev_quad, 1'b0, "strap default");
		@(posedge clock_in);
		reset_in <= 1'b0;
		wait_ready();
		$display("test power-up done");
		traffic(30);
		// soft reset, coming back in quad mode
		@(posedge clock_in);
		quad <= 1'b1;
		soft_reset <= 1'b1;
		@(posedge clock_in);
		soft_reset <= 1'b0;
		repeat (2) @(posedge clock_in);
		#1;
		check(link.link_reset_n, 1'b0, "soft reset");
		check_parked();
		wait_ready();
		check(dev_quad, 1'b1, "quad strap");
		$display("test soft reset done");
		traffic(30);
		// reset in mid-run while select 0 is driven low
		@(posedge clock_in);
		reset_in <= 1'b1;
		cs <= 4'he;
		repeat (3) @(posedge clock_in);
		#1;
		check_parked();
		check(dev_quad, 1'b0, "strap cleared");
		@(posedge clock_in);
		reset_in <= 1'b0;
		quad <= 1'b0;
		wait_ready();
		$display("test mid-run reset done");
		traffic(10);
		conclude();
	end
endmodule : rcd_reset_initialization_test
